// >>> hw/lmg_map.svh
/*
  register offsets, control bits, type codes and descriptor field positions
  for the long-mode gate checker; assumes an 8-bit byte address.
*/
`ifndef LMG_MAP_SVH
`define LMG_MAP_SVH
`define LMG_A_CTRL 8'h00
`define LMG_A_VEC 8'h04
`define LMG_A_GATE0 8'h08
`define LMG_A_GATE1 8'h0c
`define LMG_A_GATE2 8'h10
`define LMG_A_GATE3 8'h14
`define LMG_A_CS 8'h18
`define LMG_A_SYS 8'h1c
`define LMG_A_BASE 8'h20
`define LMG_A_STAT 8'h24
`define LMG_A_ERR 8'h28
`define LMG_A_OFFLO 8'h2c
`define LMG_A_OFFHI 8'h30
`define LMG_A_ENTRY 8'h34
`define LMG_C_START 0
`define LMG_C_LONG 1
`define LMG_C_SUB64 2
`define LMG_C_INT 3
`define LMG_CS_L 0
`define LMG_CS_D 1
`define LMG_T_CALL 5'h0c
`define LMG_T_INT 5'h0e
`define LMG_T_TRAP 5'h0f
`define LMG_T_CALL16 5'h04
`define LMG_T_TASK 5'h05
`define LMG_T_INT16 5'h06
`define LMG_T_TRAP16 5'h07
`define LMG_S_LDT 4'h2
`define LMG_S_TSS 4'h9
`define LMG_S_BUSY 4'hb
`define LMG_F_TYPE 44:40
`define LMG_F_SEL 31:16
`define LMG_F_IST 34:32
`define LMG_F_OFF0 15:0
`define LMG_F_OFF1 63:48
`define LMG_F_OFF2 95:64
`define LMG_VA_MSB 47
`define LMG_LONG_SHIFT 4
`define LMG_LEG_SHIFT 3
`define LMG_RESP_OK 2'b00
`define LMG_RESP_ERR 2'b10
`endif

// >>> hw/lmg_pkg.sv
/*
  types of the long-mode gate checker: state, gate kind, check result and
  status word; assumes lmg_map.svh for numeric constants.
*/
package lmg_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_check = 3'b010,
    st_done = 3'b100
  } lmg_state_t;
  typedef enum logic [2:0] {
    gk_none = 3'h0,
    gk_call = 3'h1,
    gk_int = 3'h2,
    gk_trap = 3'h3,
    gk_legacy = 3'h4
  } lmg_kind_t;
  typedef struct packed {
    logic fault;
    logic [15:0] err;
    lmg_kind_t kind;
    logic expanded;
    logic use_ist;
    logic [2:0] interrupt_stack_index;
    logic [63:0] offset;
  } lmg_result_t;
  typedef struct packed {
    logic [16:0] zero;
    logic [2:0] interrupt_stack_index;
    lmg_kind_t kind;
    logic cs_rsvd;
    logic cs_64;
    logic sys_exp;
    logic sys_legal;
    logic gate_exp;
    logic use_ist;
    logic fault;
    logic done;
    logic busy;
  } lmg_status_t;
endpackage

// >>> hw/lmg_checker.sv
/*
  long-mode gate descriptor checker with an axi4-lite register slave.
  assumes software loads the gate words, target segment bits and vector,
  then sets the start bit; one check runs at a time.
*/
// Register access over AXI4-Lite and the register addresses were decided locally.
// Operation
// - types 0ch/0eh/0fh are 64-bit call/int/trap
// - types 04h-07h raise general protection fault
// - long gates carry extra 32 offset bits
// - target segment must be long, not default-size
// - call gate reports target selector
// - interrupt/trap gate reports vector number
// - noncanonical target offset faults with zero
// - cleared upper type bits fault legacy reads
// - interrupt table entry is vector times 16
// - nonzero index selects task_state_segment stack pointer
// - zero index keeps legacy stack switch
// - system descriptors expand only in 64-bit mode
// - gates expand in both long sub-modes
// - system types 2/9/b redefined, 1/3 illegal
// - 64-bit code: d clear normal, set reserved
// - long bit selects 64-bit versus compatibility
`timescale 1ns/10ps
`include "lmg_map.svh"
module lmg_checker
  import lmg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_wr;
  logic start;
  logic ctrl_long;
  logic ctrl_sub64;
  logic ctrl_int;
  logic [7:0] vector;
  logic [31:0] gate [4];
  logic [1:0] cs_bits;
  logic [3:0] sys_type;
  logic [31:0] table_base;
  logic [127:0] gate_all;
  lmg_state_t state;
  lmg_result_t res;
  lmg_result_t next_res;
  logic [31:0] entry;
  logic sys_legal;
  logic sys_exp;
  lmg_status_t status;

  function automatic logic canonical(input logic [63:0] a);
    return (&a[63:`LMG_VA_MSB]) | ~(|a[63:`LMG_VA_MSB]);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= `LMG_A_ENTRY;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic lmg_result_t check_gate(input logic lm,
                                             input logic intr,
                                             input logic [127:0] g,
                                             input logic [1:0] cs,
                                             input logic [7:0] vec);
    lmg_result_t r;
    logic [4:0] typ;
    logic ok;
    r = '0;
    typ = g[`LMG_F_TYPE];
    ok = 1'b0;
    r.expanded = lm;
    if (lm) begin
      r.offset = {g[`LMG_F_OFF2], g[`LMG_F_OFF1], g[`LMG_F_OFF0]};
    end else begin
      r.offset = {32'h0, g[`LMG_F_OFF1], g[`LMG_F_OFF0]};
    end
    if (lm) begin
      unique case (typ)
        `LMG_T_CALL: r.kind = gk_call;
        `LMG_T_INT: r.kind = gk_int;
        `LMG_T_TRAP: r.kind = gk_trap;
        default: r.kind = gk_none;
      endcase
      ok = intr ? (r.kind == gk_int || r.kind == gk_trap) : (r.kind == gk_call);
    end else begin
      // cleared upper-half type decodes as illegal here
      unique case (typ)
        `LMG_T_CALL16, `LMG_T_TASK, `LMG_T_INT16, `LMG_T_TRAP16,
        `LMG_T_CALL, `LMG_T_INT, `LMG_T_TRAP: r.kind = gk_legacy;
        default: r.kind = gk_none;
      endcase
      ok = r.kind != gk_none;
    end
    // the count field of call gates is never read
    if (!ok) begin
      r.fault = 1'b1;
    end else if (lm && !(cs[`LMG_CS_L] && !cs[`LMG_CS_D])) begin
      r.fault = 1'b1;
      if (r.kind == gk_call) begin
        r.err = g[`LMG_F_SEL];
      end else begin
        r.err = {8'h0, vec};
      end
    end else if (lm && !canonical(r.offset)) begin
      r.fault = 1'b1;
    end
    if (lm && (r.kind == gk_int || r.kind == gk_trap)) begin
      r.interrupt_stack_index = g[`LMG_F_IST];
      r.use_ist = r.interrupt_stack_index != 3'h0;
    end
    return r;
  endfunction

  function automatic logic [31:0] entry_addr(input logic lm,
                                             input logic [31:0] base,
                                             input logic [7:0] vec);
    logic [31:0] v;
    v = {24'h0, vec};
    if (lm) begin
      return base + (v << `LMG_LONG_SHIFT);
    end
    return base + (v << `LMG_LEG_SHIFT);
  endfunction

  assign gate_all = {gate[3], gate[2], gate[1], gate[0]};
  assign do_wr = aw_held && w_held && !s_axi_bvalid;
  assign start = do_wr && aw_addr == `LMG_A_CTRL && w_strb[0] && w_data[`LMG_C_START];
  assign next_res = check_gate(ctrl_long, ctrl_int, gate_all, cs_bits, vector);

  // write address and data taken independently, answered after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_held <= 1'b0;
      aw_addr <= 8'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_held <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_wr) begin
      w_held <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LMG_RESP_OK;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_addr) ? `LMG_RESP_OK : `LMG_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // inputs are frozen while a check runs to keep results coherent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_long <= 1'b0;
      ctrl_sub64 <= 1'b0;
      ctrl_int <= 1'b0;
      vector <= 8'h0;
      cs_bits <= 2'h0;
      sys_type <= 4'h0;
      table_base <= 32'h0;
      for (int i = 0; i < 4; i++) begin
        gate[i] <= 32'h0;
      end
    end else if (do_wr && state != st_check) begin
      unique case (aw_addr)
        `LMG_A_CTRL: begin
          if (w_strb[0]) begin
            ctrl_long <= w_data[`LMG_C_LONG];
            ctrl_sub64 <= w_data[`LMG_C_SUB64];
            ctrl_int <= w_data[`LMG_C_INT];
          end
        end
        `LMG_A_VEC: vector <= w_strb[0] ? w_data[7:0] : vector;
        `LMG_A_GATE0: gate[0] <= merge(gate[0], w_data, w_strb);
        `LMG_A_GATE1: gate[1] <= merge(gate[1], w_data, w_strb);
        `LMG_A_GATE2: gate[2] <= merge(gate[2], w_data, w_strb);
        `LMG_A_GATE3: gate[3] <= merge(gate[3], w_data, w_strb);
        `LMG_A_CS: cs_bits <= w_strb[0] ? w_data[1:0] : cs_bits;
        `LMG_A_SYS: sys_type <= w_strb[0] ? w_data[3:0] : sys_type;
        `LMG_A_BASE: table_base <= merge(table_base, w_data, w_strb);
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle, st_done: state <= start ? st_check : state;
        st_check: state <= st_done;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res <= '0;
      entry <= 32'h0;
      sys_legal <= 1'b0;
      sys_exp <= 1'b0;
    end else if (state == st_check) begin
      res <= next_res;
      entry <= entry_addr(ctrl_long, table_base, vector);
      sys_legal <= !ctrl_long || sys_type == `LMG_S_LDT ||
                   sys_type == `LMG_S_TSS || sys_type == `LMG_S_BUSY;
      sys_exp <= ctrl_long && ctrl_sub64;
    end
  end

  always_comb begin
    status = '0;
    status.busy = state == st_check;
    status.done = state == st_done;
    status.fault = res.fault;
    status.use_ist = res.use_ist;
    status.gate_exp = res.expanded;
    status.sys_legal = sys_legal;
    status.sys_exp = sys_exp;
    status.cs_64 = cs_bits[`LMG_CS_L];
    status.cs_rsvd = cs_bits[`LMG_CS_L] && cs_bits[`LMG_CS_D];
    status.kind = res.kind;
    status.interrupt_stack_index = res.interrupt_stack_index;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `LMG_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? `LMG_RESP_OK : `LMG_RESP_ERR;
      unique case (s_axi_araddr)
        `LMG_A_CTRL: s_axi_rdata <= {28'h0, ctrl_int, ctrl_sub64, ctrl_long, 1'b0};
        `LMG_A_VEC: s_axi_rdata <= {24'h0, vector};
        `LMG_A_GATE0: s_axi_rdata <= gate[0];
        `LMG_A_GATE1: s_axi_rdata <= gate[1];
        `LMG_A_GATE2: s_axi_rdata <= gate[2];
        `LMG_A_GATE3: s_axi_rdata <= gate[3];
        `LMG_A_CS: s_axi_rdata <= {30'h0, cs_bits};
        `LMG_A_SYS: s_axi_rdata <= {28'h0, sys_type};
        `LMG_A_BASE: s_axi_rdata <= table_base;
        `LMG_A_STAT: s_axi_rdata <= status;
        `LMG_A_ERR: s_axi_rdata <= {16'h0, res.err};
        `LMG_A_OFFLO: s_axi_rdata <= res.offset[31:0];
        `LMG_A_OFFHI: s_axi_rdata <= res.offset[63:32];
        `LMG_A_ENTRY: s_axi_rdata <= entry;
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire [4:0] typ_w = gate[1][12:8];
  wire chk = state == st_check;
  wire cs_ok = cs_bits == 2'b01;

  call_type_a: assert property (
    chk && ctrl_long && typ_w == 5'h0c |=> res.kind == gk_call)
    else $error("call type not decoded");
  ill_type_a: assert property (
    chk && ctrl_long && typ_w >= 5'h04 && typ_w <= 5'h07 |=> res.fault && res.err == 16'h0)
    else $error("illegal gate type passed");
  gate_len_a: assert property (
    chk && ctrl_long |=> res.offset[63:32] == $past(gate[2]))
    else $error("upper offset word lost");
  cs_call_a: assert property (
    chk && ctrl_long && !ctrl_int && typ_w == 5'h0c && !cs_ok
    |=> res.fault && res.err == $past(gate[0][31:16]))
    else $error("call gate error code wrong");
  cs_vec_a: assert property (
    chk && ctrl_long && ctrl_int && typ_w == 5'h0e && !cs_ok
    |=> res.fault && res.err == {8'h0, $past(vector)})
    else $error("vector error code wrong");
  canon_pass_a: assert property (
    state == st_done && res.expanded && !res.fault |->
    (&res.offset[63:47]) || !(|res.offset[63:47]))
    else $error("noncanonical offset accepted");
  legacy_zero_a: assert property (
    chk && !ctrl_long && typ_w == 5'h00 |=> res.fault)
    else $error("zero type accepted in legacy");
  idx_scale_a: assert property (
    chk && ctrl_long |=> entry == $past(table_base) + {20'h0, $past(vector), 4'h0})
    else $error("table index not scaled by 16");
  ist_call_a: assert property (
    state == st_done && res.kind != gk_int && res.kind != gk_trap |-> res.interrupt_stack_index == 3'h0)
    else $error("stack index taken from call gate");
  ist_use_a: assert property (
    state == st_done && res.kind == gk_int |-> res.use_ist == (res.interrupt_stack_index != 3'h0))
    else $error("stack index selection wrong");
  order_a: assert property (
    chk && ctrl_long && typ_w == 5'h06 && !cs_ok |=> res.err == 16'h0)
    else $error("later check reported before type");
  start_seq_a: assert property (
    start && state != st_check |=> chk ##1 state == st_done)
    else $error("check sequence broken");
  call_ok_c: cover property (state == st_done && res.kind == gk_call && !res.fault);
  int_ist_c: cover property (state == st_done && res.use_ist && !res.fault);
  fault_c: cover property (state == st_done && res.fault && res.err != 16'h0);
endmodule

// >>> verif/lmg_sw_model.sv
/*
  software side: builds one 16-byte long-mode gate from its fields.
  assumes the field layout of lmg_map.svh; purely combinational.
*/
`timescale 1ns/10ps
`include "lmg_map.svh"
module lmg_sw_model
  import lmg_pkg::*;
(
  input wire logic [4:0] typ,
  input wire logic [15:0] sel,
  input wire logic [2:0] interrupt_stack_index,
  input wire logic [63:0] off,
  input wire logic [31:0] junk,
  output logic [127:0] gate
);
  always_comb begin
    gate = '0;
    gate[`LMG_F_OFF0] = off[15:0];
    gate[`LMG_F_SEL] = sel;
    // count left set on call gates, so an ignored field is really exercised
    gate[`LMG_F_IST] = interrupt_stack_index;
    gate[`LMG_F_TYPE] = typ;
    gate[47] = 1'b1;
    gate[`LMG_F_OFF1] = off[31:16];
    gate[`LMG_F_OFF2] = off[63:32];
    // upper type bits stay clear on call gates, dirty on int/trap gates
    if (typ == `LMG_T_INT || typ == `LMG_T_TRAP) begin
      gate[127:96] = junk;
    end
  end
endmodule

// >>> verif/tb.sv
/*
  self-checking bench for the gate checker: axi4-lite master tasks,
  expectation queues and an output monitor. assumes lmg_sw_model.
*/
`timescale 1ns/10ps
`include "lmg_map.svh"
module tb;
  import lmg_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0;
  logic [7:0] araddr = 0;
  logic [2:0] awprot = 0;
  logic [2:0] arprot = 0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, rvalid;
  logic arready;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [4:0] g_typ = 0;
  logic [15:0] g_sel = 0;
  logic [2:0] g_ist = 0;
  logic [63:0] g_off = 0;
  logic [31:0] g_junk = 0;
  logic [127:0] gate;
  logic [73:0] rq[$];
  logic [1:0] bq[$];
  logic [73:0] e;
  integer err_total = 0;
  integer checked = 0;
  integer seed = 73537;
  always #50 aclk = ~aclk;
  lmg_checker lmg_checker_inst(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(awprot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(arprot),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  lmg_sw_model lmg_sw_model_inst(.typ(g_typ), .sel(g_sel), .interrupt_stack_index(g_ist), .off(g_off),
    .junk(g_junk), .gate(gate));
  task report_and_stop;
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, x, s);
    end
  endtask
  task hang;
    err_total++;
    $display("BAD handshake exp answer seen none");
    report_and_stop;
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready && rq.size() > 0) begin
      e = rq.pop_front();
      chk($sformatf("rdata_%h", e[73:66]), rdata & e[65:34], e[31:0]);
      chk("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
    end
    if (bvalid && bready && bq.size() > 0) chk("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
  end
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awprot <= $random(seed);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    if (n >= 40) hang;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
          input logic [1:0] r);
    int n;
    rq.push_back({a, m, r, d & m});
    araddr <= a;
    arprot <= $random(seed);
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    if (n >= 40) hang;
  endtask
  // m: ctrl mode bits without start; cs: {d, l}
  task sc(input logic [3:0] m, input logic [4:0] t, input logic [1:0] cs,
          input logic [2:0] i, input logic [63:0] o);
    logic lng, intr, legal, f;
    logic [15:0] er;
    logic [31:0] b, mk;
    logic [3:0] sy;
    logic [7:0] v;
    lmg_status_t st;
    lng = m[`LMG_C_LONG];
    intr = m[`LMG_C_INT];
    g_typ <= t;
    g_sel <= $random(seed);
    g_ist <= i;
    g_off <= o;
    g_junk <= $random(seed);
    v = $random(seed);
    sy = $random(seed);
    b = $random(seed);
    @(posedge aclk);
    wr(`LMG_A_CS, {30'h0, cs}, `LMG_RESP_OK);
    wr(`LMG_A_VEC, {24'h0, v}, `LMG_RESP_OK);
    wr(`LMG_A_SYS, {28'h0, sy}, `LMG_RESP_OK);
    wr(`LMG_A_BASE, b, `LMG_RESP_OK);
    wr(`LMG_A_GATE0, gate[31:0], `LMG_RESP_OK);
    wr(`LMG_A_GATE1, gate[63:32], `LMG_RESP_OK);
    wr(`LMG_A_GATE2, gate[95:64], `LMG_RESP_OK);
    wr(`LMG_A_GATE3, gate[127:96], `LMG_RESP_OK);
    wr(`LMG_A_CTRL, {28'h0, m | 4'h1}, `LMG_RESP_OK);
    legal = lng && (intr ? (t == `LMG_T_INT || t == `LMG_T_TRAP) : t == `LMG_T_CALL);
    f = !legal || cs != 2'b01 || (o[63:47] != 17'h0 && o[63:47] != 17'h1ffff);
    er = (legal && cs != 2'b01) ? (intr ? {8'h0, v} : g_sel) : 16'h0;
    st = '0;
    st.interrupt_stack_index = (intr && lng) ? i : 3'h0;
    st.kind = lng ? (intr ? (t == `LMG_T_INT ? gk_int : gk_trap) : gk_call) : gk_legacy;
    st.cs_rsvd = cs[`LMG_CS_L] & cs[`LMG_CS_D];
    st.cs_64 = cs[`LMG_CS_L];
    st.sys_exp = lng & m[`LMG_C_SUB64];
    st.sys_legal = !lng || sy == `LMG_S_LDT || sy == `LMG_S_TSS || sy == `LMG_S_BUSY;
    st.gate_exp = lng;
    st.use_ist = intr && lng && i != 3'h0;
    st.fault = f;
    st.done = 1'b1;
    mk = !lng ? 32'h77 : (!legal ? 32'h1f7 : 32'h7fff);
    rd(`LMG_A_STAT, st, mk, `LMG_RESP_OK);
    rd(`LMG_A_ERR, {16'h0, er}, 32'hffffffff, `LMG_RESP_OK);
    if (!f) rd(`LMG_A_OFFLO, o[31:0], 32'hffffffff, `LMG_RESP_OK);
    if (!f) rd(`LMG_A_OFFHI, o[63:32], 32'hffffffff, `LMG_RESP_OK);
    if (intr && lng) rd(`LMG_A_ENTRY, b + {20'h0, v, 4'h0}, 32'hffffffff, `LMG_RESP_OK);
    rd(`LMG_A_CTRL, {28'h0, m}, 32'hf, `LMG_RESP_OK);
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`LMG_A_STAT, 32'h0, 32'hffffffff, `LMG_RESP_OK);
    sc(4'he, `LMG_T_INT, 2'b01, 3'h3, 64'h00007fff12345678);
    sc(4'ha, `LMG_T_TRAP, 2'b01, 3'h0, 64'hffff800000000010);
    sc(4'h6, `LMG_T_CALL, 2'b01, 3'h5, 64'h0000000080001000);
    for (int t = 4; t < 8; t++) sc(4'he, t[4:0], 2'b11, 3'h1, 64'h8000000000000000);
    sc(4'h6, `LMG_T_CALL, 2'b11, 3'h0, 64'h10);
    sc(4'he, `LMG_T_INT, 2'b00, 3'h0, 64'h20);
    sc(4'ha, `LMG_T_TRAP, 2'b01, 3'h2, 64'h0000800000000000);
    sc(4'he, `LMG_T_INT, 2'b10, 3'h1, 64'h0001000000000000);
    // upper half of a call gate fetched by a legacy access: type bits clear
    sc(4'h0, 5'h00, 2'b01, 3'h0, 64'h0);
    rd(8'h38, 32'h0, 32'hffffffff, `LMG_RESP_ERR);
    rd(8'h02, 32'h0, 32'hffffffff, `LMG_RESP_ERR);
    wr(8'h3c, 32'hffffffff, `LMG_RESP_ERR);
    repeat (2) @(posedge aclk);
    report_and_stop;
  end
endmodule
